// >>> mmd_regs.sv
// Management register set for the attachment, coding and negotiation spaces.
`timescale 1ns/1ps

// Functional notes
// - Attachment soft reset resets all spaces except the local interrupt status and mask, self-clears
// - Coding soft reset resets all spaces except the local interrupt status and mask, self-clears
// - Negotiation soft reset resets all spaces except the local interrupt status and mask, self-clears
// - Devices-in-package reads bits 7,3,1,0 set
// - Space responding field always reads binary 10
// - Fault and extended ability bits read zero
// - Transmit idle seen flag latches until read
// - Receive idle seen flag latches until read
// - Idle indications show live state, unlatched
// - Link status latches low until read
// - Capability reports gigabit and fast idle
// - Sixteen-bit wake fault counter clears on read
// - Extended next page intent, default one, gated
// - Status bit 7 shows extended page result
// - Local abilities writable, loaded from straps
// - Partner abilities read-only, shown live from the negotiation inputs
module mmd_regs
(
    // Clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rst_i,
    // Register port
    input  wire logic [mmd_pkg::ADDR_W-1:0]     addr_i,
    input  wire logic [mmd_pkg::DATA_W-1:0]     wdata_i,
    input  wire logic                           we_i,
    input  wire logic                           re_i,
    output logic      [mmd_pkg::DATA_W-1:0]     rdata_o,
    // Coding sublayer status
    input  wire logic                           tx_lpi_i,
    input  wire logic                           rx_lpi_i,
    input  wire logic                           link_up_i,
    input  wire logic                           wake_fault_i,
    // Negotiation results
    input  wire logic                           legacy_np_i,
    input  wire logic                           xnp_result_i,
    input  wire logic [1:0]                     partner_low_power_adv_i,
    // Configuration pins
    input  wire logic                           strap_gig_lpi_i,
    input  wire logic                           strap_fast_lpi_i,
    // Controls to the core
    output logic                                soft_reset_o,
    output logic                                xnp_enable_o,
    output logic                                local_gigabit_low_power_adv_o,
    output logic                                local_fast_low_power_adv_o,
    output logic                                irq_o
);
    import mmd_pkg::*;

    ////////////////////////////////////////////////////////////////////////

    typedef enum logic [1:0]
    {
        RS_IDLE  = 2'b01,
        RS_CLEAR = 2'b10
    } rst_state_type;

    typedef struct packed
    {
        logic [DATA_W-1:0] rdata;
        rst_state_type     rst_state;
        logic              xnp_ctrl;
        logic              loc_gig;
        logic              loc_fast;
        logic              tx_lh;
        logic              rx_lh;
        logic              lnk_ll;
        logic              tx_prev;
        logic              rx_prev;
        logic              link_prev;
        logic [1:0]        strap_done;
        logic [IRQ_N-1:0]  irq_stat;
        logic [IRQ_N-1:0]  irq_mask;
    } regs_state_type;

    regs_state_type    s_r;
    regs_state_type    s_nxt;
    logic [1:0]        strap_sync;
    logic [DATA_W-1:0] wake_count;
    logic [DATA_W-1:0] rd_word;
    logic              wake_clear;
    logic              ctrl_hit;
    logic [IRQ_N-1:0]  irq_event;

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [1:0]        sp,
                                 input logic [5:0]        off);
        hit = (a == {sp, off});
    endfunction

    ////////////////////////////////////////////////////////////////////////

    // Straps are pins, so they are synchronised before anything uses them.
    strap_sync #(.W(2)) u_strap_sync
    (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  ({strap_gig_lpi_i, strap_fast_lpi_i}),
        .sync_o (strap_sync)
    );

    assign wake_clear = (re_i && hit(addr_i, SP_PCS, OFF_WAKE_ERR))
                      || s_r.rst_state == RS_CLEAR;

    wake_err_counter #(.W(DATA_W)) u_wake_err_counter
    (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .fault_i (wake_fault_i),
        .clear_i (wake_clear),
        .count_o (wake_count)
    );

    ////////////////////////////////////////////////////////////////////////

    assign ctrl_hit = we_i && wdata_i[SOFT_RST_BIT]
                    && (hit(addr_i, SP_PMA, OFF_CTRL)
                     || hit(addr_i, SP_PCS, OFF_CTRL)
                     || hit(addr_i, SP_AN, OFF_CTRL));

    assign irq_event[IRQ_LINK]   = s_r.link_prev && !link_up_i;
    assign irq_event[IRQ_TX_LPI] = tx_lpi_i && !s_r.tx_prev;
    assign irq_event[IRQ_RX_LPI] = rx_lpi_i && !s_r.rx_prev;
    assign irq_event[IRQ_WAKE]   = wake_fault_i;

    // Read mux; unmapped addresses and reserved bits read zero.
    always_comb
    begin
        logic busy;
        busy    = (s_r.rst_state == RS_CLEAR);
        rd_word = ZERO_WORD;
        case (addr_i)
            {SP_PMA, OFF_CTRL}, {SP_PCS, OFF_CTRL}:
            begin
                rd_word[SOFT_RST_BIT] = busy;
            end
            {SP_AN, OFF_CTRL}:
            begin
                rd_word[SOFT_RST_BIT] = busy;
                rd_word[XNP_CTRL_BIT] = s_r.xnp_ctrl;
            end
            {SP_PMA, OFF_DEVS}, {SP_PCS, OFF_DEVS}, {SP_AN, OFF_DEVS}:
            begin
                rd_word = DEVS_VAL;
            end
            {SP_PMA, OFF_STAT2}:
            begin
                rd_word[15:14] = attach_space_responding;
            end
            {SP_PCS, OFF_STAT2}:
            begin
                rd_word[15:14] = coding_space_responding;
            end
            {SP_PCS, OFF_STAT1}:
            begin
                rd_word[TX_LH_BIT]  = s_r.tx_lh;
                rd_word[RX_LH_BIT]  = s_r.rx_lh;
                rd_word[TX_IND_BIT] = tx_lpi_i;
                rd_word[RX_IND_BIT] = rx_lpi_i;
                rd_word[LINK_BIT]   = s_r.lnk_ll;
            end
            {SP_PCS, OFF_LPI_CAP}:
            begin
                rd_word = LPI_CAP_VAL;
            end
            {SP_PCS, OFF_WAKE_ERR}:
            begin
                rd_word = wake_count;
            end
            {SP_AN, OFF_STAT1}:
            begin
                rd_word[XNP_RES_BIT] = xnp_result_i;
            end
            {SP_AN, OFF_LOC_ABIL}:
            begin
                rd_word[GIG_ABIL_BIT]  = s_r.loc_gig;
                rd_word[FAST_ABIL_BIT] = s_r.loc_fast;
            end
            {SP_AN, OFF_LP_ABIL}:
            begin
                rd_word[GIG_ABIL_BIT]  = partner_low_power_adv_i[1];
                rd_word[FAST_ABIL_BIT] = partner_low_power_adv_i[0];
            end
            {SP_LOCAL, OFF_IRQ_STAT}:
            begin
                rd_word[IRQ_N-1:0] = s_r.irq_stat;
            end
            {SP_LOCAL, OFF_IRQ_MASK}:
            begin
                rd_word[IRQ_N-1:0] = s_r.irq_mask;
            end
            default:
            begin
                rd_word = ZERO_WORD;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////

    always_comb
    begin
        logic st1_rd;
        st1_rd        = re_i && hit(addr_i, SP_PCS, OFF_STAT1);
        s_nxt         = s_r;
        s_nxt.rdata   = re_i ? rd_word : ZERO_WORD;
        s_nxt.tx_prev = tx_lpi_i;
        s_nxt.rx_prev = rx_lpi_i;
        s_nxt.link_prev = link_up_i;

        s_nxt.tx_lh = (s_r.tx_lh && !st1_rd) || tx_lpi_i;
        s_nxt.rx_lh = (s_r.rx_lh && !st1_rd) || rx_lpi_i;
        s_nxt.lnk_ll = st1_rd ? link_up_i : (s_r.lnk_ll && link_up_i);

        // Sticky status: a new event wins over a write-one clear.
        s_nxt.irq_stat = s_r.irq_stat | irq_event;
        if (we_i && hit(addr_i, SP_LOCAL, OFF_IRQ_STAT))
        begin
            s_nxt.irq_stat = (s_r.irq_stat & ~wdata_i[IRQ_N-1:0])
                           | irq_event;
        end
        if (we_i && hit(addr_i, SP_LOCAL, OFF_IRQ_MASK))
        begin
            s_nxt.irq_mask = wdata_i[IRQ_N-1:0];
        end

        // power-on load from straps
        // The synchroniser is cleared by reset too, so keep loading until
        // the pins have passed both stages.
        if (s_r.strap_done != STRAP_WAIT)
        begin
            s_nxt.strap_done = s_r.strap_done + 2'h1;
            s_nxt.loc_gig    = strap_sync[1];
            s_nxt.loc_fast   = strap_sync[0];
        end
        else if (we_i && hit(addr_i, SP_AN, OFF_LOC_ABIL))
        begin
            s_nxt.loc_gig  = wdata_i[GIG_ABIL_BIT];
            s_nxt.loc_fast = wdata_i[FAST_ABIL_BIT];
        end

        if (we_i && hit(addr_i, SP_AN, OFF_CTRL))
        begin
            s_nxt.xnp_ctrl = wdata_i[XNP_CTRL_BIT];
        end

        case (s_r.rst_state)
            RS_IDLE:
            begin
                if (ctrl_hit)
                begin
                    s_nxt.rst_state = RS_CLEAR;
                end
            end
            RS_CLEAR:
            begin
                s_nxt.rst_state = RS_IDLE;
                s_nxt.xnp_ctrl  = XNP_CTRL_RST;
                s_nxt.tx_lh     = 1'b0;
                s_nxt.rx_lh     = 1'b0;
                s_nxt.lnk_ll    = 1'b0;
                s_nxt.loc_gig   = strap_sync[1];
                s_nxt.loc_fast  = strap_sync[0];
            end
            default:
            begin
                s_nxt.rst_state = RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_r            <= '0;
            s_r.rst_state  <= RS_IDLE;
            s_r.xnp_ctrl   <= XNP_CTRL_RST;
            s_r.irq_mask   <= IRQ_MASK_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////

    assign rdata_o      = s_r.rdata;
    assign soft_reset_o = (s_r.rst_state == RS_CLEAR);
    assign xnp_enable_o = s_r.xnp_ctrl && legacy_np_i;
    assign local_gigabit_low_power_adv_o = s_r.loc_gig;
    assign local_fast_low_power_adv_o    = s_r.loc_fast;
    assign irq_o = |(s_r.irq_stat & s_r.irq_mask);

    ////////////////////////////////////////////////////////////////////////

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence reset_pulse_s;
        soft_reset_o ##1 !soft_reset_o;
    endsequence

    soft_rst_a: assert property (
        ctrl_hit && !soft_reset_o |=> reset_pulse_s)
        else $error("soft reset pulse missing");

    rst_restore_a: assert property (
        soft_reset_o |=> s_r.xnp_ctrl && !s_r.lnk_ll && !s_r.tx_lh)
        else $error("soft reset did not restore defaults");

    rst_clears_a: assert property (
        soft_reset_o && !wake_fault_i |=> wake_count == '0)
        else $error("soft reset did not clear counter");

    devs_read_a: assert property (
        re_i && hit(addr_i, SP_AN, OFF_DEVS) |=> rdata_o == DEVS_VAL)
        else $error("devices in package value wrong");

    status_two_a: assert property (
        re_i && hit(addr_i, SP_PMA, OFF_STAT2)
        |=> rdata_o[15:14] == 2'b10 && rdata_o[13:0] == '0)
        else $error("status two value wrong");

    tx_latch_a: assert property (
        tx_lpi_i && !soft_reset_o |=> s_r.tx_lh)
        else $error("tx idle flag not latched");

    rx_latch_a: assert property (
        rx_lpi_i && !soft_reset_o |=> s_r.rx_lh)
        else $error("rx idle flag not latched");

    live_ind_a: assert property (
        re_i && hit(addr_i, SP_PCS, OFF_STAT1)
        |=> rdata_o[9:8] == $past({tx_lpi_i, rx_lpi_i}))
        else $error("idle indication not live");

    link_low_a: assert property (
        !link_up_i |=> !s_r.lnk_ll)
        else $error("link status did not latch low");

    cap_read_a: assert property (
        re_i && hit(addr_i, SP_PCS, OFF_LPI_CAP) |=> rdata_o == 16'h0006)
        else $error("capability value wrong");

    wake_clr_a: assert property (
        re_i && hit(addr_i, SP_PCS, OFF_WAKE_ERR) && !wake_fault_i
        |=> wake_count == '0)
        else $error("wake counter not cleared by read");

    xnp_gate_a: assert property (
        !legacy_np_i |-> !xnp_enable_o)
        else $error("extended page enabled without next page");
endmodule

// >>> mmd_pkg.sv
// Constants shared by the management register set and its helpers.
package mmd_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Address layout: upper two bits pick the device space.
    localparam logic [1:0] SP_LOCAL = 2'h0;
    localparam logic [1:0] SP_PMA   = 2'h1;
    localparam logic [1:0] SP_AN    = 2'h2;
    localparam logic [1:0] SP_PCS   = 2'h3;

    localparam logic [5:0] OFF_CTRL     = 6'h00;
    localparam logic [5:0] OFF_STAT1    = 6'h01;
    localparam logic [5:0] OFF_DEVS     = 6'h05;
    localparam logic [5:0] OFF_STAT2    = 6'h08;
    localparam logic [5:0] OFF_LPI_CAP  = 6'h14;
    localparam logic [5:0] OFF_WAKE_ERR = 6'h16;
    localparam logic [5:0] OFF_LOC_ABIL = 6'h3c;
    localparam logic [5:0] OFF_LP_ABIL  = 6'h3d;
    localparam logic [5:0] OFF_IRQ_STAT = 6'h00;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h01;

    // Field positions.
    localparam int SOFT_RST_BIT  = 15;
    localparam int XNP_CTRL_BIT  = 13;
    localparam int XNP_RES_BIT   = 7;
    localparam int TX_LH_BIT     = 11;
    localparam int RX_LH_BIT     = 10;
    localparam int TX_IND_BIT    = 9;
    localparam int RX_IND_BIT    = 8;
    localparam int LINK_BIT      = 2;
    localparam int GIG_ABIL_BIT  = 2;
    localparam int FAST_ABIL_BIT = 1;

    // Fixed read values and reset values.
    localparam logic [15:0] DEVS_VAL     = 16'h008b;
    localparam logic [15:0] LPI_CAP_VAL  = 16'h0006;
    localparam logic [1:0]  attach_space_responding = 2'h2;
    localparam logic [1:0]  coding_space_responding = 2'h2;
    localparam logic        XNP_CTRL_RST = 1'b1;
    localparam logic [15:0] ZERO_WORD    = 16'h0000;
    // Edges after release until the synchronised pins are loaded into the local abilities.
    localparam logic [1:0]  STRAP_WAIT   = 2'h3;

    // Interrupt sources: link lost, tx idle, rx idle, wake fault.
    localparam int IRQ_N        = 4;
    localparam int IRQ_LINK     = 0;
    localparam int IRQ_TX_LPI   = 1;
    localparam int IRQ_RX_LPI   = 2;
    localparam int IRQ_WAKE     = 3;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // Recommended power-up reset hold and clock-before-release times.
    localparam int RST_HOLD_MS    = 100;
    localparam int CLK_SETTLE_MS  = 10;

endpackage

// >>> strap_sync.sv
// Two-stage synchroniser for the power-on configuration pins.
`timescale 1ns/1ps

module strap_sync
#(
    parameter int W = 2
)
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Pins and synchronised copy
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] sync_o
);
    typedef struct packed
    {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } sync_state_type;

    sync_state_type s_r;
    sync_state_type s_nxt;

    always_comb
    begin
        s_nxt.meta   = pin_i;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign sync_o = s_r.stable;
endmodule

// >>> wake_err_counter.sv
// Saturating wake fault counter that clears when it is read.
`timescale 1ns/1ps

module wake_err_counter
#(
    parameter int W = 16
)
(
    // Clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Events and clear
    input  wire logic         fault_i,
    input  wire logic         clear_i,
    output logic      [W-1:0] count_o
);
    typedef struct packed
    {
        logic [W-1:0] cnt;
    } wake_state_type;

    wake_state_type s_r;
    wake_state_type s_nxt;

    // A fault in the clearing cycle counts as one, so none is lost.
    always_comb
    begin
        s_nxt = s_r;
        if (clear_i)
        begin
            s_nxt.cnt = fault_i ? W'(1) : '0;
        end
        else if (fault_i && s_r.cnt != '1)
        begin
            s_nxt.cnt = s_r.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign count_o = s_r.cnt;
endmodule

// >>> core_model.sv
// Behavioural model of the coding sublayer and negotiation core.
`timescale 1ns/1ps

module core_model
(
    // Clock
    input  wire logic       clk_i,
    // Coding sublayer status
    output logic            tx_lpi_o,
    output logic            rx_lpi_o,
    output logic            link_up_o,
    output logic            wake_fault_o,
    // Negotiation results
    output logic            legacy_np_o,
    output logic            xnp_result_o,
    output logic [1:0]      partner_adv_o,
    // Configuration pins
    output logic            strap_gig_o,
    output logic            strap_fast_o
);
    // Straps stand from power-up on, so the synchronised copy is clean.
    initial
    begin
        tx_lpi_o      = 1'b0;
        rx_lpi_o      = 1'b0;
        link_up_o     = 1'b1;
        wake_fault_o  = 1'b0;
        legacy_np_o   = 1'b0;
        xnp_result_o  = 1'b0;
        partner_adv_o = 2'h0;
        strap_gig_o   = 1'b1;
        strap_fast_o  = 1'b0;
    end

    task automatic lpi(input logic tx, input logic rx);
        @(posedge clk_i);
        tx_lpi_o <= tx;
        rx_lpi_o <= rx;
    endtask

    // Moving the straps later only shows after a soft reset reloads them.
    task automatic straps(input logic gig, input logic fast);
        @(posedge clk_i);
        strap_gig_o  <= gig;
        strap_fast_o <= fast;
    endtask

    task automatic link(input logic up);
        @(posedge clk_i);
        link_up_o <= up;
    endtask

    // Wake faults come as single-cycle pulses with a quiet cycle between.
    task automatic faults(input int n);
        repeat (n)
        begin
            @(posedge clk_i);
            wake_fault_o <= 1'b1;
            @(posedge clk_i);
            wake_fault_o <= 1'b0;
        end
    endtask

    task automatic neg(input logic np, input logic xr, input logic [1:0] adv);
        @(posedge clk_i);
        legacy_np_o   <= np;
        xnp_result_o  <= xr;
        partner_adv_o <= adv;
    endtask
endmodule

// >>> tb.sv
// Self-checking testbench for the management register set.
`timescale 1ns/1ps

module tb;
    import mmd_pkg::*;

    logic        clk_i   = 1'b0;
    logic        rst_i   = 1'b1;
    logic [7:0]  addr_i  = 8'h00;
    logic [15:0] wdata_i = 16'h0000;
    logic        we_i    = 1'b0;
    logic        re_i    = 1'b0;
    logic [15:0] rdata_o;
    logic        tx_lpi, rx_lpi, link_up, wake_fault;
    logic        legacy_np, xnp_result, strap_gig, strap_fast;
    logic [1:0]  partner_adv;
    logic        soft_reset_o, xnp_enable_o, gig_adv, fast_adv, irq_o;
    int          mismatches = 0;
    int          compares   = 0;

    mmd_regs DUT
    (
        .clk_i                         (clk_i),
        .rst_i                         (rst_i),
        .addr_i                        (addr_i),
        .wdata_i                       (wdata_i),
        .we_i                          (we_i),
        .re_i                          (re_i),
        .rdata_o                       (rdata_o),
        .tx_lpi_i                      (tx_lpi),
        .rx_lpi_i                      (rx_lpi),
        .link_up_i                     (link_up),
        .wake_fault_i                  (wake_fault),
        .legacy_np_i                   (legacy_np),
        .xnp_result_i                  (xnp_result),
        .partner_low_power_adv_i       (partner_adv),
        .strap_gig_lpi_i               (strap_gig),
        .strap_fast_lpi_i              (strap_fast),
        .soft_reset_o                  (soft_reset_o),
        .xnp_enable_o                  (xnp_enable_o),
        .local_gigabit_low_power_adv_o (gig_adv),
        .local_fast_low_power_adv_o    (fast_adv),
        .irq_o                         (irq_o)
    );

    core_model core
    (
        .clk_i         (clk_i),
        .tx_lpi_o      (tx_lpi),
        .rx_lpi_o      (rx_lpi),
        .link_up_o     (link_up),
        .wake_fault_o  (wake_fault),
        .legacy_np_o   (legacy_np),
        .xnp_result_o  (xnp_result),
        .partner_adv_o (partner_adv),
        .strap_gig_o   (strap_gig),
        .strap_fast_o  (strap_fast)
    );

    initial
    begin
        forever #50 clk_i = ~clk_i;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cb(input logic got, input logic exp);
        chk({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk_i);
        re_i   <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        re_i <= 1'b0;
        #1;
        chk(rdata_o, e);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_i);
        we_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge clk_i);
        we_i <= 1'b0;
    endtask

    task automatic ro(input logic [7:0] a, input logic [15:0] d,
                      input logic [15:0] e);
        wr(a, d);
        rd(a, e);
    endtask

    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_fixed();
        rd({SP_PMA, OFF_DEVS}, 16'h008b);
        rd({SP_PCS, OFF_DEVS}, 16'h008b);
        rd({SP_AN, OFF_DEVS}, 16'h008b);
        rd({SP_PMA, OFF_STAT2}, 16'h8000);
        rd({SP_PCS, OFF_STAT2}, 16'h8000);
        rd({SP_PCS, OFF_LPI_CAP}, 16'h0006);
        rd({SP_AN, OFF_CTRL}, 16'h2000);
        rd({SP_PMA, OFF_CTRL}, 16'h0000);
        rd({SP_AN, OFF_LOC_ABIL}, 16'h0004);
        rd({SP_AN, OFF_LP_ABIL}, 16'h0000);
        rd({SP_LOCAL, OFF_IRQ_MASK}, 16'h0000);
        rd({SP_PMA, 6'h3f}, 16'h0000);
        cb(gig_adv, 1'b1);
        cb(fast_adv, 1'b0);
    endtask

    task automatic t_readonly();
        ro({SP_PMA, OFF_DEVS}, 16'hffff, 16'h008b);
        ro({SP_PMA, OFF_STAT2}, 16'hffff, 16'h8000);
        ro({SP_PCS, OFF_LPI_CAP}, 16'hffff, 16'h0006);
        ro({SP_PMA, OFF_CTRL}, 16'h7fff, 16'h0000);
        ro({SP_PCS, OFF_CTRL}, 16'h7fff, 16'h0000);
        ro({SP_AN, OFF_LOC_ABIL}, 16'hffff, 16'h0006);
        cb(fast_adv, 1'b1);
    endtask

    // Each space's reset must also undo state held by the other spaces.
    task automatic t_soft_reset();
        logic [1:0] sps [3];
        sps = '{SP_PMA, SP_PCS, SP_AN};
        foreach (sps[i])
        begin
            ro({SP_AN, OFF_LOC_ABIL}, 16'h0002, 16'h0002);
            ro({SP_AN, OFF_CTRL}, 16'h0000, 16'h0000);
            core.faults(2);
            wr({sps[i], OFF_CTRL}, 16'h8000);
            #1;
            cb(soft_reset_o, 1'b1);
            @(posedge clk_i);
            #1;
            cb(soft_reset_o, 1'b0);
            rd({sps[i], OFF_CTRL}, (sps[i] == SP_AN) ? 16'h2000 : 16'h0000);
            rd({SP_AN, OFF_CTRL}, 16'h2000);
            rd({SP_AN, OFF_LOC_ABIL}, 16'h0004);
            rd({SP_PCS, OFF_WAKE_ERR}, 16'h0000);
        end
        core.straps(1'b0, 1'b1);
        repeat (3) @(posedge clk_i);
        rd({SP_AN, OFF_LOC_ABIL}, 16'h0004);
        wr({SP_PCS, OFF_CTRL}, 16'h8000);
        rd({SP_AN, OFF_LOC_ABIL}, 16'h0002);
        cb(gig_adv, 1'b0);
        cb(fast_adv, 1'b1);
    endtask

    task automatic t_flags();
        rd({SP_PCS, OFF_STAT1}, 16'h0000);
        rd({SP_PCS, OFF_STAT1}, 16'h0004);
        core.lpi(1'b1, 1'b0);
        core.lpi(1'b0, 1'b0);
        rd({SP_PCS, OFF_STAT1}, 16'h0804);
        rd({SP_PCS, OFF_STAT1}, 16'h0004);
        core.lpi(1'b0, 1'b1);
        rd({SP_PCS, OFF_STAT1}, 16'h0504);
        core.lpi(1'b0, 1'b0);
        rd({SP_PCS, OFF_STAT1}, 16'h0404);
        rd({SP_PCS, OFF_STAT1}, 16'h0004);
        core.link(1'b0);
        core.link(1'b1);
        rd({SP_PCS, OFF_STAT1}, 16'h0000);
        rd({SP_PCS, OFF_STAT1}, 16'h0004);
    endtask

    task automatic t_wake_xnp();
        core.faults(3);
        rd({SP_PCS, OFF_WAKE_ERR}, 16'h0003);
        rd({SP_PCS, OFF_WAKE_ERR}, 16'h0000);
        core.neg(1'b0, 1'b1, 2'h2);
        rd({SP_AN, OFF_STAT1}, 16'h0080);
        cb(xnp_enable_o, 1'b0);
        core.neg(1'b1, 1'b0, 2'h2);
        rd({SP_AN, OFF_STAT1}, 16'h0000);
        cb(xnp_enable_o, 1'b1);
        ro({SP_AN, OFF_CTRL}, 16'h0000, 16'h0000);
        cb(xnp_enable_o, 1'b0);
        ro({SP_AN, OFF_LP_ABIL}, 16'hffff, 16'h0004);
    endtask

    // The interrupt output is decoded from the registered status, so allow two edges to settle.
    task automatic t_irq();
        wr({SP_LOCAL, OFF_IRQ_STAT}, 16'h000f);
        rd({SP_LOCAL, OFF_IRQ_STAT}, 16'h0000);
        core.faults(1);
        rd({SP_LOCAL, OFF_IRQ_STAT}, 16'h0008);
        cb(irq_o, 1'b0);
        ro({SP_LOCAL, OFF_IRQ_MASK}, 16'h0008, 16'h0008);
        cb(irq_o, 1'b1);
        core.link(1'b0);
        wr({SP_LOCAL, OFF_IRQ_STAT}, 16'h0008);
        repeat (2) @(posedge clk_i);
        #1;
        cb(irq_o, 1'b0);
        rd({SP_LOCAL, OFF_IRQ_STAT}, 16'h0001);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_fixed();
        t_readonly();
        t_soft_reset();
        t_flags();
        t_wake_xnp();
        t_irq();
        end_sim();
    end

    initial
    begin
        #500000;
        mismatches++;
        end_sim();
    end
endmodule
